//--- src/rid_alu.sv
`timescale 1ns/1ps
module rid_alu (
  input wire rid_pkg::rid_alu_op_type op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic [2:0] bit_idx,
  input wire logic carry_in,
  output rid_pkg::rid_alu_out_type out
);
  import rid_pkg::*;

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] mask;

  always_comb begin
    sum = {1'b0, a} + {1'b0, b};
    nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    mask = 8'h01 << bit_idx;
    out.c = carry_in;
    out.dc = 1'b0;
    case (op)
      ALU_PASS_A: out.res = a;
      ALU_PASS_B: out.res = b;
      ALU_ZERO: out.res = 8'h00;
      ALU_ADD: begin
        out.res = sum[7:0];
        out.c = sum[8];
        out.dc = nib[4];
      end
      ALU_SUB: begin
        out.res = a - b;
        out.c = (a >= b);
        out.dc = (a[3:0] >= b[3:0]);
      end
      ALU_AND: out.res = a & b;
      ALU_OR: out.res = a | b;
      ALU_XOR: out.res = a ^ b;
      ALU_COMP: out.res = ~a;
      ALU_DEC: out.res = a - 8'h01;
      ALU_INC: out.res = a + 8'h01;
      ALU_ROT_L: begin
        out.res = {a[6:0], carry_in};
        out.c = a[7];
      end
      ALU_ROT_R: begin
        out.res = {carry_in, a[7:1]};
        out.c = a[0];
      end
      ALU_SWAP: out.res = {a[3:0], a[7:4]};
      ALU_BIT_CLR: out.res = a & ~mask;
      ALU_BIT_SET: out.res = a | mask;
      default: out.res = a;
    endcase
    out.z = (out.res == 8'h00);
  end

endmodule

//--- src/rid_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - or with file, only zero flag
// RULE2 - xor with file, only zero flag
// RULE3 - rotate left through carry only
// RULE4 - rotate right through carry only
// RULE5 - decrement, no flags, skip on zero
// RULE6 - increment, no flags, skip on zero
// RULE7 - test bit, skip when bit clear
// RULE8 - test bit, skip when set, no flags
// RULE9 - or literal into accumulator, zero flag
// RULE10 - xor literal into accumulator, zero flag
// RULE11 - literal minus accumulator, carry nibble zero
// RULE12 - return with literal, two cycles
// RULE13 - standby code enters standby, updates timeout/powerdown
// RULE14 - port self-modify reads pin levels
// RULE15 - timer0 write clears assigned prescaler
// RULE16 - pc change or true skip: nop cycle
// RULE17 - instruction cycle is four clocks
// RULE18 - destination bit: 0 accumulator, 1 file
// RULE19 - decode remaining byte and bit operations
// RULE20 - call and branch, 11-bit target, stack push
// RULE21 - watchdog clear and interrupt return codes
module rid_core #(
  parameter int PCW = 13,
  parameter int STACK_DEPTH = 8,
  parameter int PORT_WIDTH = 8,
  parameter logic [6:0] TIMER0_ADDR = 7'h01,
  parameter logic [6:0] PORT_A_ADDR = 7'h05,
  parameter logic [6:0] PORT_B_ADDR = 7'h06
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic [PCW-1:0] prog_addr,
  input wire logic [rid_pkg::INSTR_W-1:0] instr_word,
  input wire logic [PCW-12:0] pc_page,
  output rid_pkg::rid_file_req_type file_req,
  input wire logic [7:0] file_rd_data,
  input wire logic [PORT_WIDTH-1:0] port_a_pins,
  input wire logic [PORT_WIDTH-1:0] port_b_pins,
  input wire logic prescaler_assigned,
  input wire logic wake_req,
  output logic prescaler_clear,
  output logic wdt_clear,
  output logic int_enable_set,
  output logic standby,
  output logic [1:0] instr_phase,
  output logic [7:0] accum,
  output rid_pkg::rid_status_type status
);
  import rid_pkg::*;

  localparam int SPW = $clog2(STACK_DEPTH);

  typedef struct packed {
    logic [1:0] phase;
    logic [PCW-1:0] pc;
    logic [INSTR_W-1:0] instr;
    logic flush;
    logic standby;
    logic [7:0] w;
    rid_status_type st;
    logic [STACK_DEPTH-1:0][PCW-1:0] stack;
    logic [SPW-1:0] sp;
    logic [7:0] fdata;
    rid_file_req_type freq;
    logic presc_clr;
    logic wdt_clr;
    logic int_en_set;
    logic [2*PORT_WIDTH-1:0] pin_s1;
    logic [2*PORT_WIDTH-1:0] pin_s2;
  } rid_state_type;

  localparam rid_state_type ST_RESET = '{
    flush: 1'b1, st: RST_STATUS, w: RST_ACCUM, default: '0};

  rid_state_type s_r;
  rid_state_type s_nxt;
  rid_dec_type dec;
  rid_alu_out_type alu_out;
  logic [7:0] alu_a;
  logic bit_val;
  logic skip;
  logic [7:0] port_val;

  //////////////////////////////////////////////////////////////////////////
  // decode
  function automatic rid_dec_type decode(input logic [INSTR_W-1:0] ins);
    rid_dec_type d;
    logic fdst;
    d = '{op: ALU_PASS_A, kind: K_PLAIN, default: '0};
    fdst = ins[DEST_POS];
    case (ins[CLASS_MSB -: 2])
      CLS_BYTE: begin
        // RULE18 destination select
        d.to_w = ~fdst;
        d.to_f = fdst;
        d.z_en = 1'b1;
        case (ins[OP_MSB -: 4])
          BY_MOVE_W: begin
            d.op = ALU_PASS_B;
            d.z_en = 1'b0;
            d.to_w = 1'b0;
            // RULE13 standby code
            // RULE21 watchdog and interrupt return
            if (fdst) begin
              d.to_f = 1'b1;
            end else if (ins == CODE_RETURN) begin
              d.kind = K_RETURN;
            end else if (ins == CODE_INT_RETURN) begin
              d.kind = K_INT_RETURN;
            end else if (ins == CODE_STANDBY) begin
              d.kind = K_STANDBY;
            end else if (ins == CODE_WDT_CLEAR) begin
              d.kind = K_WDT_CLEAR;
            end
          end
          // RULE19 remaining byte operations
          BY_CLEAR: d.op = ALU_ZERO;
          BY_SUB: begin
            d.op = ALU_SUB;
            d.c_en = 1'b1;
            d.dc_en = 1'b1;
          end
          BY_DEC: d.op = ALU_DEC;
          // RULE1 or with file
          BY_OR: d.op = ALU_OR;
          BY_AND: d.op = ALU_AND;
          // RULE2 xor with file
          BY_XOR: d.op = ALU_XOR;
          BY_ADD: begin
            d.op = ALU_ADD;
            d.c_en = 1'b1;
            d.dc_en = 1'b1;
          end
          BY_MOVE_F: d.op = ALU_PASS_A;
          BY_COMP: d.op = ALU_COMP;
          BY_INC: d.op = ALU_INC;
          // RULE5 decrement and skip
          BY_DEC_SKIP: begin
            d.op = ALU_DEC;
            d.z_en = 1'b0;
            d.kind = K_SKIP_ZERO;
          end
          // RULE4 rotate right
          BY_ROT_R: begin
            d.op = ALU_ROT_R;
            d.z_en = 1'b0;
            d.c_en = 1'b1;
          end
          // RULE3 rotate left
          BY_ROT_L: begin
            d.op = ALU_ROT_L;
            d.z_en = 1'b0;
            d.c_en = 1'b1;
          end
          BY_SWAP: begin
            d.op = ALU_SWAP;
            d.z_en = 1'b0;
          end
          // RULE6 increment and skip
          default: begin
            d.op = ALU_INC;
            d.z_en = 1'b0;
            d.kind = K_SKIP_ZERO;
          end
        endcase
      end
      CLS_BIT: begin
        case (ins[OP_MSB -: 2])
          // RULE19 bit clear and set
          BIT_CLR: begin
            d.op = ALU_BIT_CLR;
            d.to_f = 1'b1;
          end
          BIT_SET: begin
            d.op = ALU_BIT_SET;
            d.to_f = 1'b1;
          end
          // RULE7 skip if clear
          BIT_TEST_CLR: d.kind = K_SKIP_CLEAR;
          // RULE8 skip if set
          default: d.kind = K_SKIP_SET;
        endcase
      end
      CLS_JUMP: begin
        // RULE20 call or branch
        d.kind = (ins[OP_MSB] == JMP_CALL) ? K_CALL : K_BRANCH;
      end
      default: begin
        d.lit_src = 1'b1;
        d.to_w = 1'b1;
        d.z_en = 1'b1;
        if (ins[OP_MSB -: 2] == LIT_MOVE) begin
          d.z_en = 1'b0;
        end else if (ins[OP_MSB -: 2] == LIT_RET) begin
          // RULE12 return with literal
          d.z_en = 1'b0;
          d.kind = K_RET_LIT;
        end else if (ins[OP_MSB -: 4] == LIT_OR) begin
          // RULE9 or literal
          d.op = ALU_OR;
        end else if (ins[OP_MSB -: 4] == LIT_AND) begin
          d.op = ALU_AND;
        end else if (ins[OP_MSB -: 4] == LIT_XOR) begin
          // RULE10 xor literal
          d.op = ALU_XOR;
        end else if (ins[OP_MSB -: 3] == LIT_SUB) begin
          // RULE11 literal minus accumulator
          d.op = ALU_SUB;
          d.c_en = 1'b1;
          d.dc_en = 1'b1;
        end else begin
          d.op = ALU_ADD;
          d.c_en = 1'b1;
          d.dc_en = 1'b1;
        end
      end
    endcase
    return d;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // datapath
  always_comb begin
    dec = decode(s_r.instr);
    alu_a = dec.lit_src ? s_r.instr[7:0] : s_r.fdata;
    bit_val = s_r.fdata[s_r.instr[BIT_LSB +: 3]];
  end

  rid_alu u_alu (
    .op(dec.op),
    .a(alu_a),
    .b(s_r.w),
    .bit_idx(s_r.instr[BIT_LSB +: 3]),
    .carry_in(s_r.st.c),
    .out(alu_out)
  );

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.presc_clr = 1'b0;
    s_nxt.wdt_clr = 1'b0;
    s_nxt.int_en_set = 1'b0;
    s_nxt.freq.wr_en = 1'b0;
    s_nxt.pin_s1 = {port_b_pins, port_a_pins};
    s_nxt.pin_s2 = s_r.pin_s1;
    skip = 1'b0;
    port_val = file_rd_data;
    // RULE17 four clocks per cycle
    s_nxt.phase = (s_r.phase == LAST_PHASE) ? 2'h0 : s_r.phase + 2'h1;
    if (s_r.phase == 2'h0) begin
      s_nxt.freq.addr = s_r.instr[6:0];
    end
    if (s_r.phase == READ_PHASE) begin
      // RULE14 ports read at the pins
      if (s_r.instr[6:0] == PORT_A_ADDR) begin
        port_val = s_r.pin_s2[PORT_WIDTH-1:0];
      end else if (s_r.instr[6:0] == PORT_B_ADDR) begin
        port_val = s_r.pin_s2[2*PORT_WIDTH-1:PORT_WIDTH];
      end
      s_nxt.fdata = port_val;
    end
    if (s_r.phase == LAST_PHASE) begin
      if (s_r.standby) begin
        s_nxt.standby = ~wake_req;
      end else begin
        s_nxt.instr = instr_word;
        s_nxt.pc = s_r.pc + 1'b1;
        s_nxt.flush = 1'b0;
        if (!s_r.flush) begin
          // RULE18 result to accumulator or file
          if (dec.to_w) begin
            s_nxt.w = alu_out.res;
          end
          if (dec.to_f) begin
            s_nxt.freq.wr_en = 1'b1;
            s_nxt.freq.wr_data = alu_out.res;
            // RULE15 prescaler clear
            s_nxt.presc_clr = (s_r.instr[6:0] == TIMER0_ADDR) && prescaler_assigned;
          end
          if (dec.z_en) begin
            s_nxt.st.z = alu_out.z;
          end
          if (dec.c_en) begin
            s_nxt.st.c = alu_out.c;
          end
          if (dec.dc_en) begin
            s_nxt.st.dc = alu_out.dc;
          end
          case (dec.kind)
            // RULE5 skip on zero result
            K_SKIP_ZERO: skip = alu_out.z;
            // RULE7 skip when bit clear
            K_SKIP_CLEAR: skip = ~bit_val;
            // RULE8 skip when bit set
            K_SKIP_SET: skip = bit_val;
            // RULE20 push and jump
            K_CALL: begin
              s_nxt.stack[s_r.sp] = s_r.pc;
              s_nxt.sp = s_r.sp + 1'b1;
              s_nxt.pc = {pc_page, s_r.instr[TARGET_MSB:0]};
            end
            K_BRANCH: s_nxt.pc = {pc_page, s_r.instr[TARGET_MSB:0]};
            // RULE12 pop return address
            K_RETURN, K_RET_LIT: begin
              s_nxt.sp = s_r.sp - 1'b1;
              s_nxt.pc = s_r.stack[s_r.sp - 1'b1];
            end
            // RULE21 interrupt return
            K_INT_RETURN: begin
              s_nxt.sp = s_r.sp - 1'b1;
              s_nxt.pc = s_r.stack[s_r.sp - 1'b1];
              s_nxt.int_en_set = 1'b1;
            end
            // RULE13 enter standby
            K_STANDBY: begin
              s_nxt.standby = 1'b1;
              s_nxt.wdt_clr = 1'b1;
              s_nxt.st.to = 1'b1;
              s_nxt.st.pd = 1'b0;
            end
            // RULE21 watchdog restart
            K_WDT_CLEAR: begin
              s_nxt.wdt_clr = 1'b1;
              s_nxt.st.to = 1'b1;
              s_nxt.st.pd = 1'b1;
            end
            default: skip = 1'b0;
          endcase
          if (skip) begin
            s_nxt.pc = s_r.pc + 1'b1;
          end
          // RULE16 second cycle as nop
          s_nxt.flush = skip || (dec.kind inside {K_CALL, K_BRANCH, K_RETURN,
                                                  K_RET_LIT, K_INT_RETURN});
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= ST_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    prog_addr = s_r.pc;
    file_req = s_r.freq;
    prescaler_clear = s_r.presc_clr;
    wdt_clear = s_r.wdt_clr;
    int_enable_set = s_r.int_en_set;
    standby = s_r.standby;
    instr_phase = s_r.phase;
    accum = s_r.w;
    status = s_r.st;
  end

endmodule

//--- src/rid_pkg.sv
package rid_pkg;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLOCK_NS = 5;
  localparam int OSC_PER_CYCLE = 4;
  localparam int INSTR_CYCLE_NS = OSC_PER_CYCLE * CLOCK_NS;
  localparam int CYCLE_CLOCKS = INSTR_CYCLE_NS / CLOCK_NS;
  localparam logic [1:0] LAST_PHASE = 2'(CYCLE_CLOCKS - 1);
  localparam logic [1:0] READ_PHASE = 2'h1;

  ////////////////////////////////////////////////////////////////////////
  // instruction fields
  localparam int CLASS_MSB = 13;
  localparam int OP_MSB = 11;
  localparam int DEST_POS = 7;
  localparam int BIT_LSB = 7;
  localparam int TARGET_MSB = 10;
  localparam int INSTR_W = 14;

  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;

  localparam logic [3:0] BY_MOVE_W = 4'h0;
  localparam logic [3:0] BY_CLEAR = 4'h1;
  localparam logic [3:0] BY_SUB = 4'h2;
  localparam logic [3:0] BY_DEC = 4'h3;
  localparam logic [3:0] BY_OR = 4'h4;
  localparam logic [3:0] BY_AND = 4'h5;
  localparam logic [3:0] BY_XOR = 4'h6;
  localparam logic [3:0] BY_ADD = 4'h7;
  localparam logic [3:0] BY_MOVE_F = 4'h8;
  localparam logic [3:0] BY_COMP = 4'h9;
  localparam logic [3:0] BY_INC = 4'ha;
  localparam logic [3:0] BY_DEC_SKIP = 4'hb;
  localparam logic [3:0] BY_ROT_R = 4'hc;
  localparam logic [3:0] BY_ROT_L = 4'hd;
  localparam logic [3:0] BY_SWAP = 4'he;
  localparam logic [3:0] BY_INC_SKIP = 4'hf;

  localparam logic [13:0] CODE_RETURN = 14'h0008;
  localparam logic [13:0] CODE_INT_RETURN = 14'h0009;
  localparam logic [13:0] CODE_STANDBY = 14'h0063;
  localparam logic [13:0] CODE_WDT_CLEAR = 14'h0064;

  localparam logic [1:0] BIT_CLR = 2'h0;
  localparam logic [1:0] BIT_SET = 2'h1;
  localparam logic [1:0] BIT_TEST_CLR = 2'h2;
  localparam logic [1:0] BIT_TEST_SET = 2'h3;

  localparam logic JMP_CALL = 1'b0;

  localparam logic [1:0] LIT_MOVE = 2'h0;
  localparam logic [1:0] LIT_RET = 2'h1;
  localparam logic [3:0] LIT_OR = 4'h8;
  localparam logic [3:0] LIT_AND = 4'h9;
  localparam logic [3:0] LIT_XOR = 4'ha;
  localparam logic [2:0] LIT_SUB = 3'h6;
  localparam logic [2:0] LIT_ADD = 3'h7;

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [3:0] {
    ALU_PASS_A = 4'h0, ALU_PASS_B = 4'h1, ALU_ZERO = 4'h2, ALU_ADD = 4'h3,
    ALU_SUB = 4'h4, ALU_AND = 4'h5, ALU_OR = 4'h6, ALU_XOR = 4'h7,
    ALU_COMP = 4'h8, ALU_DEC = 4'h9, ALU_INC = 4'ha, ALU_ROT_L = 4'hb,
    ALU_ROT_R = 4'hc, ALU_SWAP = 4'hd, ALU_BIT_CLR = 4'he, ALU_BIT_SET = 4'hf
  } rid_alu_op_type;

  typedef enum logic [3:0] {
    K_PLAIN = 4'h0, K_CALL = 4'h1, K_BRANCH = 4'h2, K_RETURN = 4'h3,
    K_INT_RETURN = 4'h4, K_RET_LIT = 4'h5, K_STANDBY = 4'h6, K_WDT_CLEAR = 4'h7,
    K_SKIP_ZERO = 4'h8, K_SKIP_CLEAR = 4'h9, K_SKIP_SET = 4'ha
  } rid_kind_type;

  typedef struct packed {
    logic to;
    logic pd;
    logic z;
    logic dc;
    logic c;
  } rid_status_type;

  typedef struct packed {
    logic [6:0] addr;
    logic wr_en;
    logic [7:0] wr_data;
  } rid_file_req_type;

  typedef struct packed {
    rid_alu_op_type op;
    rid_kind_type kind;
    logic lit_src;
    logic to_w;
    logic to_f;
    logic z_en;
    logic c_en;
    logic dc_en;
  } rid_dec_type;

  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic dc;
    logic z;
  } rid_alu_out_type;

  localparam rid_status_type RST_STATUS = '{to: 1'b1, pd: 1'b1, z: 1'b0, dc: 1'b0, c: 1'b0};
  localparam logic [7:0] RST_ACCUM = 8'h00;

endpackage

//--- test/rid_checker.sv
`timescale 1ns/1ps
module rid_checker #(
  parameter int PCW = 13,
  parameter logic [6:0] TIMER0_ADDR = 7'h01
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [PCW-1:0] prog_addr,
  input wire rid_pkg::rid_file_req_type file_req,
  input wire logic prescaler_assigned,
  input wire logic prescaler_clear,
  input wire logic wdt_clear,
  input wire logic int_enable_set,
  input wire logic standby,
  input wire logic [1:0] instr_phase,
  input wire rid_pkg::rid_status_type status
);
  import rid_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // write pulse in phase 0, then quiet for the rest of the cycle
  sequence s_wr_tail;
    instr_phase == 2'h0 ##1 (!file_req.wr_en) [*3];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_phase_step: assert property (!standby && instr_phase != 2'h3 |=>
    instr_phase == $past(instr_phase) + 2'h1) else $error("phase did not advance");
  a_fetch_edge: assert property (!$stable(prog_addr) |->
    $past(instr_phase) == 2'h3) else $error("fetch address moved mid cycle");
  a_status_edge: assert property (!$stable(status) |->
    $past(instr_phase) == 2'h3) else $error("status moved mid cycle");
  a_write_pulse: assert property (file_req.wr_en |-> s_wr_tail)
    else $error("file write outside phase 0 or too long");
  a_presc_match: assert property (prescaler_clear == (file_req.wr_en &&
    file_req.addr == TIMER0_ADDR && prescaler_assigned)) else $error("prescaler clear wrong");
  a_standby_hold: assert property (standby && $past(standby) |->
    $stable(prog_addr)) else $error("fetch during standby");
  a_standby_flags: assert property ($rose(standby) |->
    status.to && !status.pd) else $error("standby flags wrong");
  a_standby_quiet: assert property (standby |->
    !file_req.wr_en && !int_enable_set) else $error("activity during standby");
  a_wdt_pulse: assert property (wdt_clear |-> status.to ##1 !wdt_clear)
    else $error("watchdog clear pulse wrong");
  a_ie_pulse: assert property (int_enable_set |=> (!int_enable_set) [*3])
    else $error("interrupt enable pulse too long");
endmodule

bind rid_core rid_checker #(.PCW(PCW), .TIMER0_ADDR(TIMER0_ADDR)) u_rid_checker (
  .clock(clock), .rst_n(rst_n), .prog_addr(prog_addr), .file_req(file_req),
  .prescaler_assigned(prescaler_assigned), .prescaler_clear(prescaler_clear),
  .wdt_clear(wdt_clear), .int_enable_set(int_enable_set), .standby(standby),
  .instr_phase(instr_phase), .status(status));

//--- test/rid_prog_mem.sv
`timescale 1ns/1ps
module rid_prog_mem #(
  parameter int PCW = 13,
  parameter logic [6:0] PORT_A_ADDR = 7'h05,
  parameter logic [6:0] PORT_B_ADDR = 7'h06
) (
  input wire logic clock,
  input wire logic [PCW-1:0] prog_addr,
  output logic [13:0] instr_word,
  input wire rid_pkg::rid_file_req_type file_req,
  output logic [7:0] file_rd_data,
  input wire logic ld_en,
  input wire logic [7:0] ld_addr,
  input wire logic [13:0] ld_word
);
  import rid_pkg::*;
  logic [13:0] rom [256];
  logic [7:0] fmem [128];
  initial begin
    foreach (rom[i]) rom[i] = 14'h0000;
    foreach (fmem[i]) fmem[i] = 8'h00;
  end
  always @(posedge clock) begin
    if (ld_en) rom[ld_addr] <= ld_word;
    if (file_req.wr_en) fmem[file_req.addr] <= file_req.wr_data;
  end
  // port latches read back inverted, so only the pin path gives the right value
  always_comb begin
    instr_word = rom[prog_addr[7:0]];
    file_rd_data = fmem[file_req.addr];
    if (file_req.addr == PORT_A_ADDR || file_req.addr == PORT_B_ADDR) begin
      file_rd_data = ~fmem[file_req.addr];
    end
  end
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
  import rid_pkg::*;
  logic clock, rst_n, wake_req, prescaler_assigned, ld_en;
  logic prescaler_clear, wdt_clear, int_enable_set, standby;
  logic [12:0] prog_addr;
  logic [13:0] instr_word, ld_word;
  logic [7:0] file_rd_data, port_b_pins, accum, ld_addr, port_wr;
  logic [1:0] instr_phase;
  rid_file_req_type file_req;
  rid_status_type status;
  logic [13:0] prog_q[$];
  int miscompares, num_checks, clr_cnt, ie_cnt, wdt_cnt;

  rid_core u_rid_core (
    .clock(clock), .rst_n(rst_n), .prog_addr(prog_addr), .instr_word(instr_word),
    .pc_page(2'h0), .file_req(file_req), .file_rd_data(file_rd_data),
    .port_a_pins(8'h5a), .port_b_pins(port_b_pins), .prescaler_assigned(prescaler_assigned),
    .wake_req(wake_req), .prescaler_clear(prescaler_clear), .wdt_clear(wdt_clear),
    .int_enable_set(int_enable_set), .standby(standby), .instr_phase(instr_phase),
    .accum(accum), .status(status));
  rid_prog_mem u_rid_prog_mem (
    .clock(clock), .prog_addr(prog_addr), .instr_word(instr_word), .file_req(file_req),
    .file_rd_data(file_rd_data), .ld_en(ld_en), .ld_addr(ld_addr), .ld_word(ld_word));

  always #2.5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  // pulse counters and port write capture
  always @(posedge clock) begin
    if (!rst_n) begin
      clr_cnt <= 0;
      ie_cnt <= 0;
      wdt_cnt <= 0;
      port_wr <= 8'h00;
    end else begin
      if (prescaler_clear === 1'b1) clr_cnt <= clr_cnt + 1;
      if (int_enable_set === 1'b1) ie_cnt <= ie_cnt + 1;
      if (wdt_clear === 1'b1) wdt_cnt <= wdt_cnt + 1;
      if (file_req.wr_en === 1'b1 && file_req.addr === 7'h06) port_wr <= file_req.wr_data;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] zdc();
    return 8'({status.z, status.dc, status.c});
  endfunction
  // load program under reset, release, run until standby
  task automatic run(input int t);
    int n;
    @(posedge clock);
    rst_n <= 1'b0;
    foreach (prog_q[i]) begin
      @(posedge clock);
      ld_en <= 1'b1;
      ld_addr <= 8'(i);
      ld_word <= prog_q[i];
    end
    @(posedge clock);
    ld_en <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    n = 0;
    while (standby !== 1'b1 && n < 400) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 400) begin
      miscompares++;
      results();
    end
    check(8'({status.to, status.pd}), 8'h02, "standby flags");
    if (t > 0) check(8'(n), 8'(4 * t + 4), "cycle count");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_logic();
    prog_q = '{14'h305a, 14'h00a0, 14'h300f, 14'h0420, 14'h06a0, 14'h0820, 14'h3880,
      14'h0063};
    run(8);
    check(accum, 8'h85, "or xor file");
    check(zdc(), 8'h00, "or flags");
    prog_q = '{14'h303c, 14'h3a3c, 14'h0063};
    run(3);
    check(accum, 8'h00, "xor literal");
    check(zdc(), 8'h04, "xor flags");
    $display("logic done");
  endtask
  task automatic t_rotate();
    prog_q = '{14'h3081, 14'h00a1, 14'h3a81, 14'h0da1, 14'h0c21, 14'h0063};
    run(6);
    check(accum, 8'h81, "rotate result");
    check(zdc(), 8'h04, "rotate flags");
    $display("rotate done");
  endtask
  task automatic t_skip();
    prog_q = '{14'h30ff, 14'h00a3, 14'h0f23, 14'h3801, 14'h1fa3, 14'h3802, 14'h3001,
      14'h00a2, 14'h0ba2, 14'h3804, 14'h0f22, 14'h3810, 14'h1822, 14'h3820, 14'h1c22,
      14'h3840, 14'h19a3, 14'h3880, 14'h0fa3, 14'h3801, 14'h0063};
    run(21);
    check(accum, 8'hd1, "skip path");
    check(zdc(), 8'h00, "skip flags");
    $display("skip done");
  endtask
  task automatic t_branch();
    prog_q = '{14'h2004, 14'h3801, 14'h2806, 14'h30ff, 14'h373c, 14'h30ee, 14'h0063};
    run(8);
    check(accum, 8'h3d, "call return branch_abs");
    $display("branch done");
  endtask
  task automatic t_sub();
    prog_q = '{14'h3005, 14'h3c03, 14'h0063};
    run(3);
    check(accum, 8'hfe, "literal minus");
    check(zdc(), 8'h00, "borrow flags");
    prog_q = '{14'h30fe, 14'h3dfe, 14'h0063};
    run(3);
    check(accum, 8'h00, "literal minus odd");
    check(zdc(), 8'h07, "no borrow flags");
    $display("subtract done");
  endtask
  task automatic t_misc();
    prog_q = '{14'h3035, 14'h00a4, 14'h0ea4, 14'h17a4, 14'h1024, 14'h03a4, 14'h0a24,
      14'h0224, 14'h0063};
    run(9);
    check(accum, 8'hff, "byte and bit ops");
    check(zdc(), 8'h00, "subtract flags");
    $display("misc done");
  endtask
  task automatic t_presc();
    for (int a = 1; a >= 0; a--) begin
      @(posedge clock);
      prescaler_assigned <= 1'(a);
      prog_q = '{14'h3007, 14'h0081, 14'h0a01, 14'h0986, 14'h0063};
      run(5);
      check(8'(clr_cnt), 8'(a), "prescaler clear");
      check(port_wr, 8'h69, "port from pins");
    end
    prog_q = '{14'h0805, 14'h0063};
    run(2);
    check(accum, 8'h5a, "port a from pins");
    $display("prescaler done");
  endtask
  task automatic t_wake();
    int n;
    prog_q = '{14'h2004, 14'h0063, 14'h0064, 14'h2803, 14'h0009};
    run(5);
    check(8'(ie_cnt), 8'h01, "return enable");
    @(posedge clock);
    wake_req <= 1'b1;
    n = 0;
    while (standby !== 1'b0 && n < 16) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(8'(n < 16), 8'h01, "wake");
    if (n == 16) results();
    @(posedge clock);
    wake_req <= 1'b0;
    repeat (16) @(posedge clock);
    #1;
    check(8'({status.to, status.pd}), 8'h03, "watchdog flags");
    check(8'(wdt_cnt), 8'h02, "watchdog pulses");
    $display("wake done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    ld_en = 1'b0;
    ld_addr = 8'h00;
    ld_word = 14'h0000;
    port_b_pins = 8'h96;
    prescaler_assigned = 1'b0;
    wake_req = 1'b0;
    miscompares = 0;
    num_checks = 0;
    t_logic();
    t_rotate();
    t_skip();
    t_branch();
    t_sub();
    t_misc();
    t_presc();
    t_wake();
    results();
  end
endmodule
